// ### hdl/atwic_defs.svh
`ifndef ATWIC_DEFS_SVH
`define ATWIC_DEFS_SVH

// Register map
`define ATWIC_ADDR_W 8
`define ATWIC_OFS_CFG 8'h18
`define ATWIC_OFS_CTRL 8'h19
`define ATWIC_OFS_STAT 8'h1A
`define ATWIC_OFS_OUT 8'h1B
`define ATWIC_OFS_CNT 8'h1C
`define ATWIC_CFG_RESET 8'h01
`define ATWIC_CTRL_RESET 8'h00

// Configuration byte fields
`define ATWIC_BIT_BURST 7
`define ATWIC_BIT_WAKE_IN 6
`define ATWIC_BIT_WAKE_OUT 5
`define ATWIC_BIT_WAKE_TILT 4
`define ATWIC_BIT_PULSE 3
`define ATWIC_BIT_ROLE 2
`define ATWIC_BIT_DRIVE 1
`define ATWIC_BIT_POL 0

// Control byte fields
`define ATWIC_CTRL_DEC_LSB 0
`define ATWIC_CTRL_LPM 4
`define ATWIC_CTRL_BUF_LSB 5

// Decimation limits
`define ATWIC_DEC_MAX_CODE 4'hB
`define ATWIC_DEC_MAX_SAMPLES 13'h1000

// Timing
`define ATWIC_CLK_HZ 50000000
`define ATWIC_SAMPLE_TIME_NS 312500
`define ATWIC_SAMPLE_CYCLES ((`ATWIC_SAMPLE_TIME_NS * 50) / 1000)
`define ATWIC_PULSE_TIME_NS 32000
`define ATWIC_PULSE_CYCLES ((`ATWIC_PULSE_TIME_NS * 50) / 1000)

`endif

// ### hdl/atwic_pkg.sv
package atwic_pkg;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } atwic_bus_t;

    // Detector events feeding sleep control
    typedef struct packed {
        logic inside_band;
        logic outside_band;
        logic tilt_change;
    } atwic_motion_t;

    // Acquisition sequencer states
    typedef enum logic [1:0] {
        ATWIC_IDLE = 2'b00,
        ATWIC_CONV = 2'b01,
        ATWIC_STORE = 2'b10
    } atwic_state_t;

endpackage : atwic_pkg

// ### hdl/atwic_pulse.sv
`timescale 1ns/1ps
`include "atwic_defs.svh"

// One-shot of fixed length, retriggerable
module atwic_pulse #(
    parameter int LEN = `ATWIC_PULSE_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_fire,
    output logic o_active
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    // Load on fire, count down otherwise
    always_comb begin
        cnt_d = cnt_q;
        if (i_fire) begin
            cnt_d = 16'(LEN);
        end else if (cnt_q != 16'h0000) begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    // Counter register
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_active = (cnt_q != 16'h0000);
endmodule : atwic_pulse

// ### hdl/atwic_core.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "atwic_defs.svh"

module atwic_core #(
    parameter int SAMPLE_CYCLES = `ATWIC_SAMPLE_CYCLES,
    parameter int PULSE_CYCLES = `ATWIC_PULSE_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire atwic_pkg::atwic_bus_t i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_trig_in,
    input wire logic i_boot_strap_select,
    input wire atwic_pkg::atwic_motion_t i_motion,
    input wire logic i_other_irq,
    input wire logic [15:0] i_sample,
    output logic o_irq1,
    output logic o_irq2_out,
    output logic o_irq2_oe_n,
    output logic o_wake_req,
    output logic o_buf_push,
    output logic [15:0] o_result
);
    import atwic_pkg::*;

    // Decimation count for a code; low-power forces one sample
    function automatic logic [12:0] dec_samples(input logic [3:0] code, input logic low_power_mode);
        logic [12:0] n;
        n = 13'h0001;
        if (low_power_mode) begin
            n = 13'h0001;
        end else if (code > `ATWIC_DEC_MAX_CODE) begin
            n = `ATWIC_DEC_MAX_SAMPLES;
        end else begin
            n = 13'h0001 << code;
        end
        return n;
    endfunction : dec_samples

    // Buffer mode 00 routes results to the ready flag, not the buffer
    function automatic logic direct_mode(input logic [1:0] mode);
        return (mode == 2'h0);
    endfunction : direct_mode

    // Registers
    logic [7:0] cfg_q, cfg_d;         // Configuration byte
    logic [7:0] ctrl_q, ctrl_d;       // Decimation, low-power, buffer mode
    logic ready_q, ready_d;           // Sticky sample-ready flag
    logic [7:0] rdata_q, rdata_d;     // Read data, one cycle late
    // Sequencer
    atwic_state_t st_q, st_d;
    logic [12:0] conv_q, conv_d;      // Conversions done in this set
    logic [12:0] todo_q, todo_d;      // Conversions still owed in burst
    logic [23:0] tick_q, tick_d;      // Sample time counter
    logic [28:0] acc_q, acc_d;        // Running sum
    logic [15:0] result_q, result_d;  // Averaged result
    logic push_q, push_d;             // Buffer write pulse
    // Trigger synchroniser and edge detect
    logic trig_s1_q, trig_s2_q, trig_s3_q;
    // Strap pin is asynchronous too, so it gets its own two flops
    logic boot_s1_q, boot_s2_q;
    logic store_ev; // One-cycle store strobe
    logic pulse_act; // Short ready pulse running

    // Decoded fields
    logic burst; // Burst trigger mode
    logic pulse_sel; // Pulse instead of level ready
    logic pin_trig; // Second pin is a trigger input
    logic pol; // Active-high interrupt pins
    logic low_power_mode; // Low-power mode, one sample
    logic [3:0] dec_code; // Raw averaging code
    logic [1:0] buf_mode; // Zero sends results to the flag path
    logic [12:0] n_samp; // Samples per averaged result
    logic trig_edge; // Qualified rising trigger edge
    logic axis_rd; // Host read of the result byte
    logic ready_level; // Ready pin before polarity

    assign burst = cfg_q[`ATWIC_BIT_BURST];
    // Boot strap mode takes over the pins, seen through the synchroniser
    assign pulse_sel = cfg_q[`ATWIC_BIT_PULSE] & ~boot_s2_q;
    // No trigger input in boot strap mode
    assign pin_trig = cfg_q[`ATWIC_BIT_ROLE] & ~boot_s2_q;
    // Forced active high in boot strap mode, a simplification
    assign pol = cfg_q[`ATWIC_BIT_POL] | boot_s2_q;
    assign dec_code = ctrl_q[`ATWIC_CTRL_DEC_LSB +: 4];
    assign low_power_mode = ctrl_q[`ATWIC_CTRL_LPM];
    assign buf_mode = ctrl_q[`ATWIC_CTRL_BUF_LSB +: 2];
    assign n_samp = dec_samples(dec_code, low_power_mode);
    assign axis_rd = i_bus.rd && (i_bus.addr == `ATWIC_OFS_OUT);
    // Only rising edges count, and only while the pin is an input
    assign trig_edge = pin_trig & trig_s2_q & ~trig_s3_q;

    // Two-flop synchronisers; third trigger flop keeps edge history
    // Only the second flop of each pair is read by logic
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
            boot_s1_q <= 1'b0;
            boot_s2_q <= 1'b0;
        end else begin
            trig_s1_q <= i_trig_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            boot_s1_q <= i_boot_strap_select;
            boot_s2_q <= boot_s1_q;
        end
    end

    // Register writes
    // A write lands on the edge that samples its strobe
    always_comb begin
        cfg_d = cfg_q;
        ctrl_d = ctrl_q;
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                `ATWIC_OFS_CFG: cfg_d = i_bus.wdata;
                `ATWIC_OFS_CTRL: ctrl_d = i_bus.wdata;
                default: ;
            endcase
        end
    end

    // Acquisition sequencer
    always_comb begin
        st_d = st_q;
        conv_d = conv_q;
        todo_d = todo_q;
        tick_d = tick_q;
        acc_d = acc_q;
        result_d = result_q;
        push_d = 1'b0;
        store_ev = 1'b0;
        unique case (st_q)
            ATWIC_IDLE: begin
                // An edge during a conversion is dropped; the host paces them
                if (trig_edge) begin
                    st_d = ATWIC_CONV;
                    tick_d = 24'(SAMPLE_CYCLES);
                    // Burst owes the rest of the set; single owes one
                    if (burst && !low_power_mode) begin
                        todo_d = n_samp - conv_q;
                    end else begin
                        todo_d = 13'h0001;
                    end
                end
            end
            // One slot per sample; a burst owes several
            ATWIC_CONV: begin
                // Count down the sample slot
                if (tick_q > 24'h000001) begin
                    tick_d = tick_q - 24'h000001;
                end else begin
                    // Sample taken on the last tick of the slot
                    acc_d = acc_q + 29'(i_sample);
                    conv_d = conv_q + 13'h0001;
                    todo_d = todo_q - 13'h0001;
                    tick_d = 24'(SAMPLE_CYCLES);
                    if (conv_q + 13'h0001 >= n_samp) begin
                        st_d = ATWIC_STORE;
                    end else if (todo_q == 13'h0001) begin
                        st_d = ATWIC_IDLE; // Wait for next edge
                    end
                end
            end
            ATWIC_STORE: begin
                // Result, flag and buffer strobe all leave from here
                // Divide by the sample count, a power of two
                result_d = 16'(acc_q >> dec_code_shift(dec_code, low_power_mode));
                acc_d = 29'h00000000;
                conv_d = 13'h0000;
                todo_d = 13'h0000;
                store_ev = 1'b1;
                push_d = !direct_mode(buf_mode);
                st_d = ATWIC_IDLE;
            end
            // Unused code falls back to idle
            default: st_d = ATWIC_IDLE;
        endcase
    end

    // Shift amount for averaging
    // Power-of-two counts make the average a plain shift
    function automatic logic [3:0] dec_code_shift(input logic [3:0] code, input logic low_power_mode);
        logic [3:0] s;
        s = code;
        if (low_power_mode) begin
            s = 4'h0;
        end else if (code > `ATWIC_DEC_MAX_CODE) begin
            s = 4'hC;
        end
        return s;
    endfunction : dec_code_shift

    // Ready flag: set wins over the clearing read
    always_comb begin
        ready_d = ready_q;
        // Reading the result byte acknowledges the level
        if (axis_rd) begin
            ready_d = 1'b0;
        end
        // A store in the same cycle as the read keeps the flag up
        if (store_ev && direct_mode(buf_mode)) begin
            ready_d = 1'b1;
        end
    end

    // Read mux, data valid one cycle after strobe
    // Idle cycles return zero so stale data never lingers
    always_comb begin
        rdata_d = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `ATWIC_OFS_CFG: rdata_d = cfg_q;
                `ATWIC_OFS_CTRL: rdata_d = ctrl_q;
                `ATWIC_OFS_STAT: rdata_d = {5'h00, st_q, ready_q};
                `ATWIC_OFS_OUT: rdata_d = result_q[15:8];
                `ATWIC_OFS_CNT: rdata_d = conv_q[7:0];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // State registers
    // Polarity comes up active high so the pins idle low
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cfg_q <= `ATWIC_CFG_RESET;
            ctrl_q <= `ATWIC_CTRL_RESET;
            ready_q <= 1'b0;
            rdata_q <= 8'h00;
            st_q <= ATWIC_IDLE;
            conv_q <= 13'h0000;
            todo_q <= 13'h0000;
            tick_q <= 24'h000000;
            acc_q <= 29'h00000000;
            result_q <= 16'h0000;
            push_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            ctrl_q <= ctrl_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            st_q <= st_d;
            conv_q <= conv_d;
            todo_q <= todo_d;
            tick_q <= tick_d;
            acc_q <= acc_d;
            result_q <= result_d;
            push_q <= push_d;
        end
    end

    // Short pulse on each store, only for the flag path
    // Length is a parameter; the nominal width is 32 us
    atwic_pulse #(
        .LEN(PULSE_CYCLES)
    ) u_pulse (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_fire(store_ev && direct_mode(buf_mode)),
        .o_active(pulse_act)
    );

    // Level or pulse form, then ORed with other events
    assign ready_level = (pulse_sel ? pulse_act : ready_q) | i_other_irq;
    // Polarity: high when set, low otherwise
    assign o_irq1 = pol ? ready_level : ~ready_level;
    // Second pin drives only when not a trigger input
    assign o_irq2_out = pol ? i_other_irq : ~i_other_irq;
    // Trigger role releases the pin; the driven value is then unused
    assign o_irq2_oe_n = pin_trig;

    // Wake request from enabled detector events
    // Detector events arrive on this clock, so no synchroniser
    assign o_wake_req = (cfg_q[`ATWIC_BIT_WAKE_IN] & i_motion.inside_band)
        | (cfg_q[`ATWIC_BIT_WAKE_OUT] & i_motion.outside_band)
        | (cfg_q[`ATWIC_BIT_WAKE_TILT] & i_motion.tilt_change);

    // Data outputs straight from flops
    assign o_rdata = rdata_q;
    assign o_buf_push = push_q;
    assign o_result = result_q;
endmodule : atwic_core

// ### test/atwic_core_monitor.sv
`timescale 1ns/1ps
module atwic_core_monitor (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire atwic_pkg::atwic_bus_t i_bus,
    input wire logic [7:0] o_rdata,
    input wire logic i_boot_strap_select,
    input wire atwic_pkg::atwic_motion_t i_motion,
    input wire logic o_irq2_oe_n,
    input wire logic o_wake_req,
    input wire logic o_buf_push
);
    import atwic_pkg::*;
    logic [7:0] cfg_q, cfg_d, ctl_q, ctl_d; // Shadow registers
    logic rd_cfg, rd_ctl, rd_bad; // Read decodes
    logic boot_s1_q, boot_s2_q; // Mirror of the strap synchroniser
    // Mirror host writes, so no peeking inside is needed
    always_comb begin
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        if (i_bus.wr && i_bus.addr == 8'h18) cfg_d = i_bus.wdata;
        if (i_bus.wr && i_bus.addr == 8'h19) ctl_d = i_bus.wdata;
        rd_cfg = i_bus.rd && i_bus.addr == 8'h18;
        rd_ctl = i_bus.rd && i_bus.addr == 8'h19;
        rd_bad = i_bus.rd && (i_bus.addr < 8'h18 || i_bus.addr > 8'h1C);
    end
    // Shadows take reset values alongside the design
    always_ff @(posedge i_core_clk) begin
        cfg_q <= i_reset_n ? cfg_d : 8'h01;
        ctl_q <= i_reset_n ? ctl_d : 8'h00;
        boot_s1_q <= i_reset_n ? i_boot_strap_select : 1'b0;
        boot_s2_q <= i_reset_n ? boot_s1_q : 1'b0;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    AST_WAKE: assert property (o_wake_req == |(cfg_q[6:4] & i_motion))
        else $error("wake request mismatch");
    AST_OE: assert property (o_irq2_oe_n == (cfg_q[2] && !boot_s2_q))
        else $error("pin direction mismatch");
    AST_RD_IDLE: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_RD_CFG: assert property (rd_cfg |=> o_rdata == $past(cfg_q))
        else $error("config readback mismatch");
    AST_RD_CTL: assert property (rd_ctl |=> o_rdata == $past(ctl_q))
        else $error("control readback mismatch");
    AST_RD_BAD: assert property (rd_bad |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_PUSH_MODE: assert property (o_buf_push |-> ctl_q[6:5] != 2'b00)
        else $error("buffer push in direct mode");
    AST_PUSH_ONE: assert property (o_buf_push |=> !o_buf_push)
        else $error("buffer push too long");
endmodule : atwic_core_monitor
bind atwic_core atwic_core_monitor i_mon (.i_core_clk, .i_reset_n, .i_bus, .o_rdata,
    .i_boot_strap_select, .i_motion, .o_irq2_oe_n, .o_wake_req, .o_buf_push);

// ### test/atwic_host_trig.sv
`timescale 1ns/1ps
// Host timer pin: one request gives one rising edge
module atwic_host_trig (
    input wire logic i_core_clk,
    input wire logic i_fire,
    output logic o_trig
);
    logic [2:0] hold_q = 3'h0; // Cycles left high
    // Held high long enough to pass a two-flop sync
    always @(posedge i_core_clk) begin
        if (i_fire) hold_q <= 3'h4;
        else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    end
    assign o_trig = hold_q != 3'h0;
endmodule : atwic_host_trig

// ### test/atwic_core_tb_top.sv
`timescale 1ns/1ps
module atwic_core_tb_top;
    import atwic_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, fire = 1'b0, boot = 1'b0, other = 1'b0;
    logic trig, irq1, irq2, oe_n, wake, push; // Pin and flag levels
    logic [7:0] rdata;
    logic [15:0] smp = 16'h1234, result; // Constant sample, so mean equals it
    atwic_bus_t bus = '0;
    atwic_motion_t mot = '0;
    int failures = 0, tests_run = 0, cyc = 0, c, lo, n[4] = '{2048, 4096, 4096, 1};
    logic [7:0] ctl[4] = '{8'h2B, 8'h2C, 8'h2F, 8'h32}; // Codes 11, 12, 15, low power
    atwic_core #(.SAMPLE_CYCLES(4), .PULSE_CYCLES(3)) i_dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_trig_in(oe_n ? trig : irq2), .i_boot_strap_select(boot), .i_motion(mot),
        .i_other_irq(other), .i_sample(smp), .o_irq1(irq1), .o_irq2_out(irq2),
        .o_irq2_oe_n(oe_n), .o_wake_req(wake), .o_buf_push(push), .o_result(result));
    atwic_host_trig i_host (.i_core_clk(clk), .i_fire(fire), .o_trig(trig));
    initial forever #10 clk = ~clk;
    // The four burst codes need about 41k cycles in all; the longest code about 16k
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude;
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus <= '0;
        #1 chk("reg read", 16'(e), 16'(rdata));
    endtask : rdc
    // One trigger edge; count cycles to a push and low cycles of the ready pin
    task automatic pulse(input int w);
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        c = 0;
        lo = 0;
        while (c < w && push !== 1'b1) begin
            @(posedge clk);
            #1 c++;
            lo += int'(irq1 === 1'b0);
        end
    endtask : pulse
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h18, 8'h01);
        rdc(8'h19, 8'h00);
        wr(8'h20, 8'hFF);
        rdc(8'h20, 8'h00);
        // Other events on the second pin, either polarity
        for (int p = 0; p < 2; p++) begin
            wr(8'h18, 8'(p));
            for (int o = 0; o < 2; o++) begin
                @(posedge clk) other <= 1'(o);
                repeat (3) @(posedge clk);
                #1 chk("irq2", 16'(o == p), 16'(irq2));
            end
            @(posedge clk) other <= 1'b0;
        end
        // Every enable mask against every event mix
        for (int e = 0; e < 8; e++) begin
            wr(8'h18, {1'b0, 3'(e), 4'h1});
            for (int m = 0; m < 8; m++) begin
                @(posedge clk) mot <= 3'(m);
                #1 chk("wake", 16'(|(e & m)), 16'(wake));
            end
            @(posedge clk) mot <= '0;
        end
        wr(8'h18, 8'h05);
        @(posedge clk) #1 chk("oe_n", 16'h0001, 16'(oe_n));
        // Single edges, four per set, two sets back to back
        wr(8'h19, 8'h02);
        for (int k = 1; k <= 8; k++) begin
            pulse(30);
            if (k % 4 == 3) chk("ready early", 16'h0000, 16'(irq1));
            if (k % 4 == 0) begin
                chk("ready", 16'h0001, 16'(irq1));
                chk("result", 16'h1234, result);
                rdc(8'h1B, 8'h12);
                @(posedge clk) #1 chk("ready clear", 16'h0000, 16'(irq1));
            end
        end
        // Pulse width, either polarity, over a 40 cycle window
        wr(8'h19, 8'h00);
        for (int p = 0; p < 2; p++) begin
            wr(8'h18, 8'h0C | 8'(p));
            pulse(40);
            chk("pulse", p ? 16'h0025 : 16'h0003, 16'(lo));
        end
        // Boot strap mode falls back to the level form of ready
        @(posedge clk) boot <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("boot ready", 16'h0001, 16'(irq1));
        @(posedge clk) boot <= 1'b0;
        rdc(8'h1B, 8'h12);
        // Burst span per code, results to buffer
        wr(8'h18, 8'h85);
        for (int i = 0; i < 4; i++) begin
            wr(8'h19, ctl[i]);
            pulse(20000);
            chk("span", 16'h0001, 16'(c >= n[i] * 4 && c <= n[i] * 4 + 12));
            chk("no ready", 16'h0000, 16'(irq1));
        end
        wr(8'h18, 8'h81);
        pulse(40);
        chk("no trigger", 16'h0028, 16'(c));
        conclude();
    end
endmodule : atwic_core_tb_top
